// >>> sim/qbx_expander_tb_top.sv
`timescale 1ns/1ps
`include "qbx_cfg.svh"

module qbx_expander_tb_top
    import qbx_pkg::*;
;
    // ---------------------------------------------------------------
    // Signals.
    // ---------------------------------------------------------------
    logic      sys_clk = 1'b0;  // System clock, 100 ns.
    logic      link_clk = 1'b0; // Link clock, 12 ns.
    logic      rst = 1'b1;      // Reset, active high.
    logic      ce = 1'b1;       // Clock enable, dropped low once in the select test.
    logic      scl;             // Serial clock from the master.
    logic      m_sda;           // Master data drive.
    logic      sda_wire;        // Resolved serial data wire.
    logic      sda_o;
    logic      sda_oe_n;
    logic [2:0] asel = 3'h5;    // Address select pins.
    qbx_byte_t ext = 8'hff;     // External drive, high means released.
    qbx_byte_t pins;            // Resolved port wires.
    qbx_byte_t port_o;
    qbx_byte_t port_oe_n;
    qbx_byte_t boost;
    logic      int_o;
    logic      int_oe_n;
    int        failures = 0;
    int        comparisons = 0;
    int        cycles = 0;
    qbx_byte_t q;
    logic      a;

    // Clocks, the link clock offset so its edges never meet the other.
    always #50 sys_clk = ~sys_clk;
    initial
    begin
        #2.5;
        forever #6 link_clk = ~link_clk;
    end

    // Wired-AND of every party on the open-drain lines.
    assign sda_wire = m_sda & (sda_oe_n | sda_o);
    assign pins = ext & (port_oe_n | port_o);

    qbx_master_model i_mst (.clk_i(sys_clk), .sda_i(sda_wire),
                            .scl_o(scl), .sda_o(m_sda));

    qbx_expander i_dut (.sys_clk_i(sys_clk), .link_clk_i(link_clk),
        .rst_i(rst), .ce_i(ce), .scl_i(scl), .sda_i(sda_wire),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_select_i(asel),
        .port_pin_i(pins), .port_pin_o(port_o), .port_oe_n_o(port_oe_n),
        .pullup_boost_o(boost), .int_o(int_o), .int_oe_n_o(int_oe_n));

    // ---------------------------------------------------------------
    // Compare and report.
    // ---------------------------------------------------------------
    task automatic chk8(input qbx_byte_t got, input qbx_byte_t exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // A hung run is cut short and counted as a mismatch.
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            failures++;
            close_out();
        end
    end

    // Address byte worked out from the fixed bits and the select pins.
    function automatic qbx_byte_t addr(input logic rw);
        return {`QBX_ADDR_HIGH, asel, rw};
    endfunction

    // One complete single-byte write.
    task automatic wr(input qbx_byte_t d);
        i_mst.start();
        i_mst.xfer(addr(1'b0), 1'b1, q, a);
        i_mst.xfer(d, 1'b1, q, a);
        chk1(a, 1'b0);
        i_mst.stop();
    endtask

    // ---------------------------------------------------------------
    // Scenarios.
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk8(port_oe_n, `QBX_PORT_RESET);
        chk8(boost, 8'h00);
        chk1(int_oe_n, 1'b1);
        chk1(sda_oe_n, 1'b1);
        $display("test reset done");
    endtask

    // Foreign address ignored, then two bytes back to back.
    task automatic t_write();
        qbx_byte_t prev;
        qbx_byte_t d;
        prev = `QBX_PORT_RESET;
        i_mst.start();
        i_mst.xfer({`QBX_ADDR_HIGH, 3'h2, 1'b0}, 1'b1, q, a);
        chk1(a, 1'b1);
        i_mst.stop();
        i_mst.start();
        i_mst.xfer(addr(1'b0), 1'b1, q, a);
        chk1(a, 1'b0);
        for (int k = 0; k < 2; k++)
        begin
            d = (k == 0) ? 8'h5a : 8'ha5;
            for (int i = 7; i >= 0; i--)
                i_mst.bit_io(d[i], a);
            chk8(port_oe_n, prev);
            i_mst.bit_io(1'b1, a);
            chk1(a, 1'b0);
            i_mst.wt(8);
            chk8(port_oe_n, d);
            chk8(boost, d);
            prev = d;
        end
        i_mst.stop();
        chk8(boost, 8'ha5);
        i_mst.start();
        i_mst.wt(6);
        chk8(boost, 8'h00);
        i_mst.stop();
        chk8(port_oe_n, 8'ha5);
        $display("test write done");
    endtask

    // Two-byte read of mixed inputs and outputs, last byte refused.
    task automatic t_read();
        wr(8'hcf);
        ext <= 8'h9f;
        i_mst.wt(20);
        i_mst.start();
        i_mst.xfer(addr(1'b1), 1'b1, q, a);
        chk1(a, 1'b0);
        i_mst.xfer(8'hff, 1'b0, q, a);
        chk8(q, 8'h8f);
        i_mst.xfer(8'hff, 1'b1, q, a);
        chk8(q, 8'h8f);
        i_mst.wt(2);
        chk1(sda_oe_n, 1'b1);
        i_mst.stop();
        $display("test read done");
    endtask

    // Interrupt raised, restored, cleared by read and by write.
    task automatic t_irq();
        i_mst.half = 25;
        ext <= ext ^ 8'h01;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b0);
        ext <= ext ^ 8'h01;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b1);
        ext <= ext ^ 8'h01;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b0);
        i_mst.start();
        i_mst.xfer(addr(1'b1), 1'b1, q, a);
        i_mst.wt(6);
        chk1(int_oe_n, 1'b1);
        i_mst.xfer(8'hff, 1'b1, q, a);
        chk8(q, 8'h8e);
        i_mst.stop();
        ext <= ext ^ 8'h02;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b0);
        wr(8'hcf);
        chk1(int_oe_n, 1'b1);
        $display("test interrupt done");
    endtask

    // New select pins move the address; a low enable freezes the port.
    task automatic t_select();
        asel <= 3'h2;
        i_mst.wt(20);
        i_mst.start();
        i_mst.xfer({`QBX_ADDR_HIGH, 3'h5, 1'b0}, 1'b1, q, a);
        chk1(a, 1'b1);
        i_mst.stop();
        wr(8'hcf);
        chk8(port_oe_n, 8'hcf);
        asel <= 3'h5;
        ce <= 1'b0;
        i_mst.wt(4);
        ext <= ext ^ 8'h04;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b1);
        ce <= 1'b1;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b0);
        ext <= ext ^ 8'h04;
        i_mst.wt(6);
        chk1(int_oe_n, 1'b1);
        i_mst.wt(20);
        $display("test select done");
    endtask

    // Main sequence.
    initial
    begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        i_mst.wt(20);
        t_reset();
        t_write();
        t_read();
        t_irq();
        t_select();
        close_out();
    end
endmodule

// >>> sim/qbx_master_model.sv
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Serial bus master that stands in for the host controller.
// ---------------------------------------------------------------
module qbx_master_model
    import qbx_pkg::*;
(
    // Clock and resolved data wire.
    input  wire logic clk_i,
    input  wire logic sda_i,
    // Driven levels, high means released to the pull-up.
    output logic      scl_o,
    output logic      sda_o
);
    // Half a serial clock period in system clocks; raise it to go slow.
    int half = 15;

    // Both lines start released, so the bus is idle.
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Waits a number of system clock edges.
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Opens a transfer from an idle bus.
    task automatic start();
        sda_o <= 1'b1;
        scl_o <= 1'b1;
        wt(half);
        sda_o <= 1'b0;
        wt(half);
        scl_o <= 1'b0;
        wt(2);
    endtask

    // Sends one bit and samples the wire at the end of the high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_o <= b;
        wt(half);
        scl_o <= 1'b1;
        wt(half);
        r = sda_i;
        scl_o <= 1'b0;
        wt(2);
    endtask

    // Moves a byte, most significant bit first, then the acknowledge bit.
    task automatic xfer(input qbx_byte_t d, input logic ack_in,
                        output qbx_byte_t q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(ack_in, ack);
    endtask

    // Closes a transfer and leaves the bus idle.
    task automatic stop();
        sda_o <= 1'b0;
        wt(half);
        scl_o <= 1'b1;
        wt(half);
        sda_o <= 1'b1;
        wt(half);
    endtask
endmodule

// >>> verilog/qbx_cfg.svh
`ifndef QBX_CFG_SVH
`define QBX_CFG_SVH

// Port width and the level every latch takes after reset.
`define QBX_PORT_W     8
`define QBX_PORT_RESET 8'hff
// Constant low level driven on every open-drain port pin.
`define QBX_PORT_LOW   8'h00
// Upper four address bits fixed by the device variant.
`define QBX_ADDR_HIGH  4'h4
// Bit counter values.
`define QBX_CNT_ZERO   4'h0
`define QBX_CNT_ONE    4'h1
`define QBX_CNT_BYTE   4'h8

`endif

// >>> verilog/qbx_expander.sv
`timescale 1ns/1ps
`include "qbx_cfg.svh"

module qbx_expander
    import qbx_pkg::*;
(
    // Clocks, reset and enable.
    input  wire logic       sys_clk_i,
    input  wire logic       link_clk_i,
    input  wire logic       rst_i,
    input  wire logic       ce_i,
    // Serial bus pins.
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    // Address select pins.
    input  wire logic [2:0] addr_select_i,
    // Port pins.
    input  wire qbx_byte_t  port_pin_i,
    output qbx_byte_t       port_pin_o,
    output qbx_byte_t       port_oe_n_o,
    output qbx_byte_t       pullup_boost_o,
    // Interrupt pin.
    output logic            int_o,
    output logic            int_oe_n_o
);

    //------------------------------------------------------------
    // State and events
    //------------------------------------------------------------

    qbx_sys_t  sr;      // System domain state.
    qbx_sys_t  sn;      // Its next value.
    qbx_link_t lr;      // Link domain state.
    qbx_link_t ln;      // Its next value.

    logic l_rise;       // Serial clock rose.
    logic l_fall;       // Serial clock fell.
    logic l_start;      // Start condition seen.
    logic l_stop;       // Stop condition seen.
    logic s_wr_evt;     // A data byte arrived for the latch.
    logic s_rd_evt;     // A byte is being read out.
    logic s_scl_fall;   // Serial clock fell, system view.

    // Link edges use only second and third synchroniser stages.
    assign l_rise  = lr.scl_s & ~lr.scl_p;
    assign l_fall  = ~lr.scl_s & lr.scl_p;
    assign l_start = lr.scl_s & lr.scl_p & lr.sda_p & ~lr.sda_s;
    assign l_stop  = lr.scl_s & lr.scl_p & ~lr.sda_p & lr.sda_s;

    // Write and read events come from synchronised toggles, the clock fall from the clock synchroniser.
    assign s_wr_evt   = sr.wtog_s ^ sr.wtog_p;
    assign s_rd_evt   = sr.rtog_s ^ sr.rtog_p;
    assign s_scl_fall = ~sr.scl_s & sr.scl_p;

    //------------------------------------------------------------
    // Link domain: serial bus slave
    //------------------------------------------------------------

    // Computes the next link state from bus edges.
    always_comb
    begin
        ln        = lr;
        ln.rst_m  = rst_i;
        ln.rst_s  = lr.rst_m;
        ln.ce_m   = ce_i;
        ln.ce_s   = lr.ce_m;
        ln.scl_m  = scl_i;
        ln.scl_s  = lr.scl_m;
        ln.sda_m  = sda_i;
        ln.sda_s  = lr.sda_m;
        ln.asel_m = addr_select_i;
        ln.asel_s = lr.asel_m;
        ln.ptog_m = sr.pub_tog;
        ln.ptog_s = lr.ptog_m;
        if (lr.rst_s)
        begin
            // Defaults while reset is held.
            ln.scl_p     = 1'b1;
            ln.sda_p     = 1'b1;
            ln.pub_ack   = 1'b0;
            ln.snap      = `QBX_PORT_RESET;
            ln.state     = st_idle;
            ln.cnt       = `QBX_CNT_ZERO;
            ln.sh        = `QBX_PORT_RESET;
            ln.rw        = 1'b0;
            ln.mack      = 1'b0;
            ln.drive_low = 1'b0;
            ln.wr_data   = `QBX_PORT_RESET;
            ln.wr_tog    = 1'b0;
            ln.rd_tog    = 1'b0;
        end
        else if (lr.ce_s)
        begin
            ln.scl_p = lr.scl_s;
            ln.sda_p = lr.sda_s;
            // Take a fresh snapshot whenever one is offered.
            if (lr.ptog_s != lr.pub_ack)
            begin
                ln.snap    = sr.pub_data;
                ln.pub_ack = lr.ptog_s;
            end
            if (l_start)
            begin
                // A start restarts addressing from any state.
                ln.state     = st_addr;
                ln.cnt       = `QBX_CNT_ZERO;
                ln.drive_low = 1'b0;
            end
            else if (l_stop)
            begin
                // A stop releases the bus from any state.
                ln.state     = st_idle;
                ln.drive_low = 1'b0;
            end
            else
            begin
                case (lr.state)
                    st_addr, st_wr_data:
                    begin
                        // Bits are taken while the clock is high.
                        if (l_rise)
                        begin
                            ln.sh  = {lr.sh[6:0], lr.sda_s};
                            ln.cnt = lr.cnt + `QBX_CNT_ONE;
                        end
                        else if (l_fall && lr.cnt == `QBX_CNT_BYTE)
                        begin
                            if (lr.state == st_wr_data)
                            begin
                                ln.drive_low = 1'b1;
                                ln.state     = st_wr_ack;
                            end
                            else if (lr.sh[7:1] ==
                                     {`QBX_ADDR_HIGH, lr.asel_s})
                            begin
                                ln.drive_low = 1'b1;
                                ln.rw        = lr.sh[0];
                                ln.state     = st_addr_ack;
                            end
                            else
                            begin
                                // Another slave is addressed.
                                ln.state = st_idle;
                            end
                        end
                    end
                    st_addr_ack, st_rd_ack:
                    begin
                        // Master answer is sampled at the clock rise.
                        if (l_rise)
                        begin
                            ln.mack = ~lr.sda_s;
                        end
                        else if (l_fall)
                        begin
                            ln.cnt       = `QBX_CNT_ZERO;
                            ln.drive_low = 1'b0;
                            if (lr.state == st_rd_ack && !lr.mack)
                            begin
                                // No acknowledge: leave data high.
                                ln.state = st_idle;
                            end
                            else if (lr.rw)
                            begin
                                // Load the current pin levels.
                                ln.sh        = lr.snap;
                                ln.drive_low = ~lr.snap[7];
                                ln.rd_tog    = ~lr.rd_tog;
                                ln.state     = st_rd_data;
                            end
                            else
                            begin
                                ln.state = st_wr_data;
                            end
                        end
                    end
                    st_wr_ack:
                    begin
                        // Byte is handed over after its acknowledge.
                        if (l_fall)
                        begin
                            ln.drive_low = 1'b0;
                            ln.wr_data   = lr.sh;
                            ln.wr_tog    = ~lr.wr_tog;
                            ln.cnt       = `QBX_CNT_ZERO;
                            ln.state     = st_wr_data;
                        end
                    end
                    st_rd_data:
                    begin
                        // Shift out, highest bit first.
                        if (l_rise)
                        begin
                            ln.cnt = lr.cnt + `QBX_CNT_ONE;
                        end
                        else if (l_fall)
                        begin
                            if (lr.cnt == `QBX_CNT_BYTE)
                            begin
                                ln.drive_low = 1'b0;
                                ln.state     = st_rd_ack;
                            end
                            else
                            begin
                                ln.sh        = {lr.sh[6:0], 1'b0};
                                ln.drive_low = ~lr.sh[6];
                            end
                        end
                    end
                    default:
                    begin
                        // Idle waits for a start.
                        ln.drive_low = 1'b0;
                    end
                endcase
            end
        end
    end

    // Registers the link state.
    always_ff @(posedge link_clk_i)
    begin
        lr <= ln;
    end

    //------------------------------------------------------------
    // System domain: port latch, boost and interrupt
    //------------------------------------------------------------

    // Computes the next system state.
    always_comb
    begin
        sn        = sr;
        sn.pin_m  = port_pin_i;
        sn.pin_s  = sr.pin_m;
        sn.scl_m  = scl_i;
        sn.scl_s  = sr.scl_m;
        sn.wtog_m = lr.wr_tog;
        sn.wtog_s = sr.wtog_m;
        sn.rtog_m = lr.rd_tog;
        sn.rtog_s = sr.rtog_m;
        sn.ack_m  = lr.pub_ack;
        sn.ack_s  = sr.ack_m;
        if (rst_i)
        begin
            // Every pin starts high, ready as an input.
            sn.pins     = `QBX_PORT_RESET;
            sn.scl_p    = 1'b1;
            sn.wtog_p   = 1'b0;
            sn.rtog_p   = 1'b0;
            sn.pub_tog  = 1'b0;
            sn.pub_data = `QBX_PORT_RESET;
            sn.latch    = `QBX_PORT_RESET;
            sn.base     = `QBX_PORT_RESET;
            sn.boost    = `QBX_PORT_LOW;
            sn.int_act  = 1'b0;
        end
        else if (ce_i)
        begin
            sn.pins   = sr.pin_s;
            sn.scl_p  = sr.scl_s;
            sn.wtog_p = sr.wtog_s;
            sn.rtog_p = sr.rtog_s;
            // Offer a new snapshot once the last one was taken.
            if (sr.ack_s == sr.pub_tog)
            begin
                sn.pub_data = sr.pin_s & sr.latch;
                sn.pub_tog  = ~sr.pub_tog;
            end
            if (s_scl_fall)
            begin
                sn.boost = `QBX_PORT_LOW;
            end
            if (s_wr_evt)
            begin
                sn.latch = lr.wr_data;
                sn.boost = lr.wr_data;
            end
            // An access takes the present pins as the new baseline.
            if (s_wr_evt || s_rd_evt)
            begin
                sn.base = sn.pins;
            end
            sn.int_act = (sn.pins != sn.base);
        end
    end

    // Registers the system state.
    always_ff @(posedge sys_clk_i)
    begin
        sr <= sn;
    end

    //------------------------------------------------------------
    // Pin drivers
    //------------------------------------------------------------

    // Open-drain outputs only ever pull low.
    assign port_pin_o     = `QBX_PORT_LOW;
    assign port_oe_n_o    = sr.latch;
    assign pullup_boost_o = sr.boost;
    assign sda_o          = 1'b0;
    assign sda_oe_n_o     = ~lr.drive_low;
    assign int_o          = 1'b0;
    assign int_oe_n_o     = ~sr.int_act;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------

    chk_latch_reset: assert property (@(posedge sys_clk_i)
        rst_i |=> sr.latch == `QBX_PORT_RESET)
        else $error("latch not high after reset");
    chk_latch_write: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) s_wr_evt && ce_i |=> sr.latch == lr.wr_data)
        else $error("latch missed written byte");
    chk_latch_hold: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) !s_wr_evt |=> $stable(sr.latch))
        else $error("latch changed without a write");
    chk_int_clear: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) (s_wr_evt || s_rd_evt) && ce_i |=> !sr.int_act)
        else $error("interrupt not cleared by access");
    chk_int_edge: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && !s_wr_evt && !s_rd_evt
        && sr.pin_s != sr.base |=> sr.int_act)
        else $error("pin change did not raise interrupt");
    chk_boost_off: assert property (@(posedge sys_clk_i)
        disable iff (rst_i) ce_i && s_scl_fall && !s_wr_evt
        |=> sr.boost == `QBX_PORT_LOW)
        else $error("boost still on after clock fall");
    chk_stop_idle: assert property (@(posedge link_clk_i)
        disable iff (lr.rst_s) lr.ce_s && l_stop && !l_start
        |=> lr.state == st_idle && !lr.drive_low)
        else $error("stop did not release the bus");
    chk_addr_ack: assert property (@(posedge link_clk_i)
        disable iff (lr.rst_s) lr.ce_s && lr.state == st_addr && l_fall
        && lr.cnt == `QBX_CNT_BYTE && !l_start && !l_stop
        && lr.sh[7:1] == {`QBX_ADDR_HIGH, lr.asel_s}
        |=> lr.drive_low && lr.state == st_addr_ack)
        else $error("own address not acknowledged");
    chk_wr_hand: assert property (@(posedge link_clk_i)
        disable iff (lr.rst_s) lr.ce_s && lr.state == st_wr_ack && l_fall
        && !l_start && !l_stop |=> lr.wr_tog != $past(lr.wr_tog))
        else $error("acknowledged byte not handed over");
    chk_nack_release: assert property (@(posedge link_clk_i)
        disable iff (lr.rst_s) lr.ce_s && lr.state == st_rd_ack && l_fall
        && !lr.mack && !l_start && !l_stop
        |=> !lr.drive_low && lr.state == st_idle)
        else $error("data not released after no acknowledge");

    cov_write: cover property (@(posedge sys_clk_i) s_wr_evt);
    cov_read: cover property (@(posedge link_clk_i)
        lr.state == st_rd_data);
    cov_int: cover property (@(posedge sys_clk_i)
        sr.int_act ##1 !sr.int_act);

endmodule

// >>> verilog/qbx_pkg.sv
`include "qbx_cfg.svh"

package qbx_pkg;

    // One port byte.
    typedef logic [`QBX_PORT_W-1:0] qbx_byte_t;

    // Serial bus slave states.
    typedef enum logic [2:0]
    {
        st_idle, st_addr, st_addr_ack, st_wr_data,
        st_wr_ack, st_rd_data, st_rd_ack
    } qbx_bus_state_t;

    // State of the system clock domain.
    typedef struct packed
    {
        qbx_byte_t pin_m;     // Pin synchroniser, first stage.
        qbx_byte_t pin_s;     // Pin synchroniser, second stage.
        qbx_byte_t pins;      // Last sampled pin levels.
        logic      scl_m;     // Serial clock synchroniser.
        logic      scl_s;
        logic      scl_p;
        logic      wtog_m;    // Write event toggle synchroniser.
        logic      wtog_s;
        logic      wtog_p;
        logic      rtog_m;    // Read event toggle synchroniser.
        logic      rtog_s;
        logic      rtog_p;
        logic      ack_m;     // Snapshot acknowledge synchroniser.
        logic      ack_s;
        logic      pub_tog;   // Snapshot publish toggle.
        qbx_byte_t pub_data;  // Snapshot offered to the link side.
        qbx_byte_t latch;     // Latched output levels.
        qbx_byte_t base;      // Pin levels at the last access.
        qbx_byte_t boost;     // Strong pull-up enables.
        logic      int_act;   // Interrupt asserted.
    } qbx_sys_t;

    // State of the link clock domain.
    typedef struct packed
    {
        logic           rst_m;     // Reset synchroniser.
        logic           rst_s;
        logic           ce_m;      // Clock enable synchroniser.
        logic           ce_s;
        logic           scl_m;     // Serial clock synchroniser.
        logic           scl_s;
        logic           scl_p;
        logic           sda_m;     // Serial data synchroniser.
        logic           sda_s;
        logic           sda_p;
        logic [2:0]     asel_m;    // Address select synchroniser.
        logic [2:0]     asel_s;
        logic           ptog_m;    // Publish toggle synchroniser.
        logic           ptog_s;
        logic           pub_ack;   // Snapshot acknowledge toggle.
        qbx_byte_t      snap;      // Latest pin snapshot.
        qbx_bus_state_t state;     // Bus state.
        logic [3:0]     cnt;       // Bit counter.
        qbx_byte_t      sh;        // Shift register.
        logic           rw;        // Direction of this transfer.
        logic           mack;      // Master acknowledged the byte.
        logic           drive_low; // Pull serial data low.
        qbx_byte_t      wr_data;   // Byte handed to the port latch.
        logic           wr_tog;    // Write event toggle.
        logic           rd_tog;    // Read event toggle.
    } qbx_link_t;

endpackage
